// File: design/isp_pkg.sv
// Purpose: shared constants of the interrupt source prioritizer
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes: offsets are byte addresses inside the block's window
package isp_pkg;
    localparam int unsigned LVL_W = 4;
    localparam logic [3:0] LVL_MAX = 4'hf;
    localparam logic [3:0] LVL_NONE = 4'h0;
    localparam logic [3:0] LVLPIN_IDLE_CODE = 4'hf;
    localparam int unsigned NPINS = 4;
    localparam int unsigned VEC_W = 7;
    localparam logic [6:0] VEC_DEBUG = 7'h0d;
    localparam logic [6:0] VEC_AUTO_BASE = 7'h40;
    localparam int unsigned VTAB_SHIFT = 2;
    // source slots in default ranking order, lowest index wins a tie
    localparam int unsigned SRC_DEBUG = 0;
    localparam int unsigned SRC_LVLPIN = 1;
    localparam int unsigned SRC_PIN0 = 2;
    localparam int unsigned SRC_PERI0 = 6;
    // register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SENSE = 8'h04;
    localparam logic [7:0] OFS_PINPRI = 8'h08;
    localparam logic [7:0] OFS_PRI0 = 8'h0c;
    localparam logic [7:0] OFS_PVEC = 8'h20;
    localparam logic [7:0] OFS_VBASE = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] REG_STRIDE = 8'h04;
    localparam int unsigned OFS_W = 8;
    // interrupt_control_reg fields
    localparam int unsigned CTRL_VECMODE_BIT = 0;
    localparam int unsigned CTRL_PINMODE_BIT = 1;
    // pin_sense_ctrl_status fields
    localparam int unsigned SNS_FLAG_LSB = 0;
    localparam int unsigned SNS_LVL_LSB = 4;
    localparam int unsigned SNS_SEL_LSB = 8;
    localparam logic [1:0] SNS_LOW = 2'h0;
    localparam logic [1:0] SNS_FALL = 2'h1;
    localparam logic [1:0] SNS_RISE = 2'h2;
    localparam logic [1:0] SNS_BOTH = 2'h3;
    // status register fields
    localparam int unsigned STAT_BUSY_BIT = 15;
    localparam int unsigned STAT_LVL_LSB = 8;
    // priority_regs layout
    localparam int unsigned NUM_PRI_REGS = 5;
    localparam int unsigned PRI_FIELDS_PER_REG = 4;
    localparam int unsigned SRC_PER_FIELD = 2;
    localparam int unsigned PRI_REG_W = 16;
    // reset values
    localparam logic [15:0] RST_PRI = 16'h0000;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [6:0] RST_VEC = 7'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_PINS = 4'hf;
    // AHB-Lite
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// File: design/isp_rank_if.sv
// Purpose: carries candidate requests to the ranker and its choice back
// Assumes: one request and one level per source slot
// Notes: none
`timescale 1ns/1ps
interface isp_rank_if #(parameter int N = 46);
    logic [N-1:0] req;
    logic [N-1:0][3:0] prio;
    logic [3:0] mask;
    logic win_valid;
    logic [$clog2(N)-1:0] win_idx;
    logic [3:0] win_level;
    modport rank (input req, input prio, input mask, output win_valid, output win_idx, output win_level);
    modport user (output req, output prio, output mask, input win_valid, input win_idx, input win_level);
endinterface

// File: design/isp_ranker.sv
// Purpose: picks the highest level request that beats the cpu mask
// Assumes: slot order is the fixed default order
// Notes: strict compare keeps the lowest slot on equal levels
`timescale 1ns/1ps
module isp_ranker #(
    parameter int N = 46
) (
    // ranking port
    isp_rank_if.rank rk
);
    logic best_v;
    logic [$clog2(N)-1:0] best_i;
    logic [3:0] best_l;

    always_comb begin
        best_v = 1'b0;
        best_i = '0;
        best_l = isp_pkg::LVL_NONE;
        for (int i = 0; i < N; i++) begin
            if (rk.req[i] && rk.prio[i] != isp_pkg::LVL_NONE
                && rk.prio[i] > rk.mask
                && rk.prio[i] > best_l) begin
                best_v = 1'b1;
                best_i = ($clog2(N))'(i);
                best_l = rk.prio[i];
            end
        end
    end

    assign rk.win_valid = best_v;
    assign rk.win_idx = best_i;
    assign rk.win_level = best_l;
endmodule

// File: design/isp_top.sv
// Purpose: ranks debug, level-pin and peripheral interrupts, supplies vectors
// Assumes: inputs synchronous to hclk; peripheral requests held until serviced
// Notes: pin mode and vector mode come from interrupt_control_reg
//
// Notes on behaviour
// - debug port request ranks at level 15; acceptance sets mask 15.
// - encoded pins request one of levels 15 to 1, priority equals level.
// - code 0 is level 15, higher codes lower; pairs share vectors 71..64.
// - external vector mode takes pin and encoded-level vectors 0..127 from the vector input lines.
// - external mode pin acceptance drives level, strobes fetch, captures vector.
// - accepting an encoded level loads mask level with that level.
// - pin mode select set makes each pin an independent source.
// - each pin senses low level, rising, falling or both edges.
// - each pin has its own priority 0..15 in pin_priority_reg.
// - external mode pin interrupt drives pin priority and fetch strobe.
// - accepting a pin interrupt loads mask with that pin's priority.
// - during fetch chip selects stay high; upper address lines undefined.
// - fetch is stretched by wait input; no programmed wait states.
// - each peripheral source gets its own distinct vector.
// - peripheral levels 0..15 come from the five priority registers.
// - accepting a peripheral interrupt loads mask with its level.
// - sources sharing a priority field rank in fixed hardware order.
// - reset clears every peripheral priority to 0.
// - equal levels resolve by fixed default source order.
// - vector table address is computed from vector and fetched.
// - level 0 means masked, never accepted.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module isp_top #(
    parameter int N_PERI = 40
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt sources
    input wire logic debug_port_req,
    input wire logic [3:0] level_request_pins,
    input wire logic [N_PERI-1:0] peri_irq,
    // cpu exception port
    input wire logic [3:0] cpu_mask_level,
    output logic exc_valid,
    input wire logic exc_ready,
    output logic [6:0] exc_vector,
    output logic [31:0] exc_table_addr,
    output logic [3:0] exc_mask_level,
    // external bus during vector fetch
    input wire logic [7:0] vector_input_lines,
    input wire logic wait_n,
    output logic vector_fetch_strobe_n,
    output logic [3:0] level_output_lines,
    output logic [4:0] chip_selects_n,
    output logic [20:0] upper_address_lines,
    // normal bus values from the bus controller
    input wire logic [3:0] bus_low_addr,
    input wire logic [4:0] bus_cs_n,
    input wire logic [20:0] bus_upper_addr
);
    localparam int NSRC = isp_pkg::SRC_PERI0 + N_PERI;
    localparam int SW = $clog2(NSRC);
    localparam int MAX_PERI = isp_pkg::NUM_PRI_REGS * isp_pkg::PRI_FIELDS_PER_REG * isp_pkg::SRC_PER_FIELD;

    if (N_PERI < 1 || N_PERI > MAX_PERI) begin : g_bad_peri
        $error("N_PERI out of range for the priority register fields");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DELIVER} isp_state_e;

    function automatic logic [3:0] pri_field(input logic [isp_pkg::NUM_PRI_REGS-1:0][15:0] regs, input int f);
        int r;
        int s;
        r = f / isp_pkg::PRI_FIELDS_PER_REG;
        s = f % isp_pkg::PRI_FIELDS_PER_REG;
        pri_field = regs[r][(isp_pkg::PRI_FIELDS_PER_REG - 1 - s) * isp_pkg::LVL_W +: isp_pkg::LVL_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [1:0] ctrl_q;
    logic [7:0] sense_sel_q;
    logic [15:0] pinpri_q;
    logic [isp_pkg::NUM_PRI_REGS-1:0][15:0] pri_q;
    logic [6:0] pvec_q;
    logic [31:0] vbase_q;
    logic [3:0] pins_prev_q;
    logic [3:0] edge_flag_q;
    logic debug_flag_q;
    isp_state_e state_q;
    logic [3:0] lvl_q;
    logic [6:0] vec_q;
    logic [31:0] tab_q;

    isp_rank_if #(.N(NSRC)) rk ();

    wire vector_mode_select = ctrl_q[isp_pkg::CTRL_VECMODE_BIT];
    wire pinmode = ctrl_q[isp_pkg::CTRL_PINMODE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, OKAY always
    logic dp_wr_q;
    logic dp_rd_q;
    logic [7:0] dp_addr_q;

    wire ap_take = hsel && htrans[isp_pkg::HTRANS_ACTIVE_BIT] && hready;
    wire wr_ctrl = dp_wr_q && dp_addr_q == isp_pkg::OFS_CTRL;
    wire wr_sense = dp_wr_q && dp_addr_q == isp_pkg::OFS_SENSE;
    wire wr_pinpri = dp_wr_q && dp_addr_q == isp_pkg::OFS_PINPRI;
    wire wr_pvec = dp_wr_q && dp_addr_q == isp_pkg::OFS_PVEC;
    wire wr_vbase = dp_wr_q && dp_addr_q == isp_pkg::OFS_VBASE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= '0;
        end else begin
            dp_wr_q <= ap_take && hwrite;
            dp_rd_q <= ap_take && !hwrite;
            dp_addr_q <= ap_take ? haddr[isp_pkg::OFS_W-1:0] : dp_addr_q;
        end
    end

    logic [31:0] rd_mux;
    logic [31:0] pri_rd;

    always_comb begin
        pri_rd = isp_pkg::RST_WORD;
        for (int r = 0; r < isp_pkg::NUM_PRI_REGS; r++) begin
            if (dp_addr_q == isp_pkg::OFS_W'(isp_pkg::OFS_PRI0 + isp_pkg::REG_STRIDE * r)) begin
                pri_rd = {16'h0000, pri_q[r]};
            end
        end
    end

    always_comb begin
        case (dp_addr_q)
            isp_pkg::OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
            isp_pkg::OFS_SENSE: rd_mux = {16'h0000, sense_sel_q, level_request_pins, edge_flag_q};
            isp_pkg::OFS_PINPRI: rd_mux = {16'h0000, pinpri_q};
            isp_pkg::OFS_PVEC: rd_mux = {25'h000_0000, pvec_q};
            isp_pkg::OFS_VBASE: rd_mux = vbase_q;
            isp_pkg::OFS_STAT: begin
                rd_mux = isp_pkg::RST_WORD;
                rd_mux[isp_pkg::STAT_BUSY_BIT] = state_q != ST_IDLE;
                rd_mux[isp_pkg::STAT_LVL_LSB +: isp_pkg::LVL_W] = lvl_q;
                rd_mux[isp_pkg::VEC_W-1:0] = vec_q;
            end
            default: rd_mux = pri_rd;
        endcase
    end

    assign hrdata = dp_rd_q ? rd_mux : isp_pkg::RST_WORD;
    assign hreadyout = 1'b1;
    assign hresp = isp_pkg::HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= isp_pkg::RST_CTRL;
            sense_sel_q <= isp_pkg::RST_SEL;
            pinpri_q <= isp_pkg::RST_PRI;
            pvec_q <= isp_pkg::RST_VEC;
            vbase_q <= isp_pkg::RST_WORD;
        end else begin
            if (wr_ctrl) ctrl_q <= hwdata[1:0];
            if (wr_sense) sense_sel_q <= hwdata[isp_pkg::SNS_SEL_LSB +: 8];
            if (wr_pinpri) pinpri_q <= hwdata[15:0];
            if (wr_pvec) pvec_q <= hwdata[isp_pkg::VEC_W-1:0];
            if (wr_vbase) vbase_q <= hwdata;
        end
    end

    for (genvar r = 0; r < isp_pkg::NUM_PRI_REGS; r++) begin : g_pri
        wire wr_pri = dp_wr_q && dp_addr_q == isp_pkg::OFS_W'(isp_pkg::OFS_PRI0 + isp_pkg::REG_STRIDE * r);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pri_q[r] <= isp_pkg::RST_PRI;
            end else if (wr_pri) begin
                pri_q[r] <= hwdata[isp_pkg::PRI_REG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source detection
    wire accept = state_q == ST_IDLE && rk.win_valid;
    wire [3:0] lvlpin_lvl = isp_pkg::LVL_MAX - level_request_pins;
    wire lvlpin_req = !pinmode && level_request_pins != isp_pkg::LVLPIN_IDLE_CODE;
    wire [3:0] fall = pins_prev_q & ~level_request_pins;
    wire [3:0] rise = ~pins_prev_q & level_request_pins;
    wire [3:0] clr_w1 = wr_sense ? hwdata[isp_pkg::SNS_FLAG_LSB +: isp_pkg::NPINS] : 4'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_prev_q <= isp_pkg::RST_PINS;
            debug_flag_q <= 1'b0;
        end else begin
            pins_prev_q <= level_request_pins;
            // a new request in the accepting cycle stays pending
            debug_flag_q <= debug_port_req || (debug_flag_q && !(accept && rk.win_idx == SW'(isp_pkg::SRC_DEBUG)));
        end
    end

    assign rk.mask = cpu_mask_level;
    assign rk.req[isp_pkg::SRC_DEBUG] = debug_flag_q;
    assign rk.prio[isp_pkg::SRC_DEBUG] = isp_pkg::LVL_MAX;
    assign rk.req[isp_pkg::SRC_LVLPIN] = lvlpin_req;
    assign rk.prio[isp_pkg::SRC_LVLPIN] = lvlpin_lvl;

    for (genvar p = 0; p < isp_pkg::NPINS; p++) begin : g_pin
        wire [1:0] sel = sense_sel_q[2*p +: 2];
        wire hit = (sel == isp_pkg::SNS_FALL && fall[p]) || (sel == isp_pkg::SNS_RISE && rise[p])
            || (sel == isp_pkg::SNS_BOTH && (fall[p] || rise[p]));
        wire taken = accept && rk.win_idx == SW'(isp_pkg::SRC_PIN0 + p);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                edge_flag_q[p] <= 1'b0;
            end else begin
                // set wins over acceptance and software clear
                edge_flag_q[p] <= (pinmode && hit) || (edge_flag_q[p] && !taken && !clr_w1[p]);
            end
        end
        assign rk.req[isp_pkg::SRC_PIN0 + p] = pinmode
            && (sel == isp_pkg::SNS_LOW ? !level_request_pins[p] : edge_flag_q[p]);
        assign rk.prio[isp_pkg::SRC_PIN0 + p] = pinpri_q[p*isp_pkg::LVL_W +: isp_pkg::LVL_W];
    end

    for (genvar i = 0; i < N_PERI; i++) begin : g_peri
        assign rk.req[isp_pkg::SRC_PERI0 + i] = peri_irq[i];
        // neighbours in one field tie, and the lower slot wins
        assign rk.prio[isp_pkg::SRC_PERI0 + i] = pri_field(pri_q, i / isp_pkg::SRC_PER_FIELD);
    end

    isp_ranker #(.N(NSRC)) u_ranker (
        .rk(rk.rank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // acceptance and vector supply
    wire win_is_pin = rk.win_idx == SW'(isp_pkg::SRC_LVLPIN)
        || (rk.win_idx >= SW'(isp_pkg::SRC_PIN0) && rk.win_idx < SW'(isp_pkg::SRC_PERI0));
    wire go_fetch = win_is_pin && vector_mode_select;

    logic [6:0] auto_vec;
    always_comb begin
        if (rk.win_idx == SW'(isp_pkg::SRC_DEBUG)) begin
            auto_vec = isp_pkg::VEC_DEBUG;
        end else if (win_is_pin) begin
            auto_vec = isp_pkg::VEC_AUTO_BASE + {3'h0, 1'b0, rk.win_level[3:1]};
        end else begin
            auto_vec = pvec_q + isp_pkg::VEC_W'(rk.win_idx - SW'(isp_pkg::SRC_PERI0));
        end
    end

    // top vector line is held low by the agent; it is dropped here
    wire [6:0] ext_vec = vector_input_lines[isp_pkg::VEC_W-1:0];
    wire fetch_done = state_q == ST_FETCH && wait_n;
    wire load_auto = accept && !go_fetch;
    wire [6:0] vec_d = load_auto ? auto_vec : ext_vec;
    wire [31:0] tab_d = vbase_q + {23'h00_0000, vec_d, 2'h0};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            lvl_q <= isp_pkg::LVL_NONE;
            vec_q <= isp_pkg::RST_VEC;
            tab_q <= isp_pkg::RST_WORD;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        lvl_q <= rk.win_level;
                        state_q <= go_fetch ? ST_FETCH : ST_DELIVER;
                    end
                end
                ST_FETCH: begin
                    if (fetch_done) begin
                        state_q <= ST_DELIVER;
                    end
                end
                ST_DELIVER: begin
                    if (exc_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (load_auto || fetch_done) begin
                vec_q <= vec_d;
                tab_q <= tab_d;
            end
        end
    end

    wire fetching = state_q == ST_FETCH;

    assign exc_valid = state_q == ST_DELIVER;
    assign exc_vector = vec_q;
    assign exc_table_addr = tab_q;
    assign exc_mask_level = lvl_q;
    assign vector_fetch_strobe_n = !fetching;
    assign level_output_lines = fetching ? lvl_q : bus_low_addr;
    assign chip_selects_n = fetching ? 5'h1f : bus_cs_n;
    assign upper_address_lines = fetching ? 21'h00_0000 : bus_upper_addr;
endmodule

// File: tb/isp_assertions.sv
// Purpose: port checks on the interrupt source prioritizer
// Assumes: cpu mask held steady while a request waits
// Notes: bound to isp_top from the bench top file
`timescale 1ns/1ps
module isp_assertions (
    // clock and reset
    input logic hclk,
    input logic hresetn,
    // bus answer
    input logic hreadyout,
    input logic hresp,
    // cpu side
    input logic [3:0] cpu_mask_level,
    input logic exc_valid,
    input logic exc_ready,
    input logic [6:0] exc_vector,
    input logic [3:0] exc_mask_level,
    // fetch pins
    input logic [7:0] vector_input_lines,
    input logic wait_n,
    input logic vector_fetch_strobe_n,
    input logic [3:0] level_output_lines,
    input logic [4:0] chip_selects_n,
    input logic [3:0] bus_low_addr,
    input logic [4:0] bus_cs_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_fetch_cs_high: assert property (!vector_fetch_strobe_n |-> chip_selects_n == 5'h1f)
        else $error("chip select active in vector fetch");
    a_fetch_pass: assert property (vector_fetch_strobe_n |-> chip_selects_n == bus_cs_n && level_output_lines == bus_low_addr)
        else $error("bus pins not passed through");
    a_fetch_wait: assert property (!vector_fetch_strobe_n && !wait_n |=> !vector_fetch_strobe_n)
        else $error("fetch ended while wait held");
    a_fetch_bound: assert property ($fell(vector_fetch_strobe_n) |-> ##[1:20] vector_fetch_strobe_n)
        else $error("fetch strobe stuck");
    a_fetch_deliver: assert property (!vector_fetch_strobe_n && wait_n |=> vector_fetch_strobe_n && exc_valid)
        else $error("no delivery after fetch");
    a_fetch_vector: assert property (!vector_fetch_strobe_n && wait_n |=> {1'b0, exc_vector} == ($past(vector_input_lines) & 8'h7f))
        else $error("fetched vector not captured");
    a_fetch_quiet: assert property (exc_valid |-> vector_fetch_strobe_n)
        else $error("fetch during delivery");
    a_valid_hold: assert property (exc_valid && !exc_ready |=> exc_valid && $stable(exc_vector) && $stable(exc_mask_level))
        else $error("delivery changed before taken");
    a_ready_drop: assert property (exc_valid && exc_ready |=> !exc_valid)
        else $error("delivery stayed after taken");
    a_accept_level: assert property ($rose(exc_valid) |-> exc_mask_level > cpu_mask_level)
        else $error("accepted level not above mask");
    a_debug_mask: assert property (exc_valid && exc_vector == 7'h0d |-> exc_mask_level == 4'hf)
        else $error("debug request not at level 15");
endmodule

// File: tb/isp_vec_agent.sv
// Purpose: outside logic that answers the vector fetch cycle
// Assumes: wait line pulled up outside fetch
// Notes: data lines toggle when not fetched
`timescale 1ns/1ps
module isp_vec_agent (
    // clock and reset
    input logic hclk,
    input logic hresetn,
    // fetch cycle
    input logic vector_fetch_strobe_n,
    input logic [6:0] vec,
    input int waits,
    output logic [7:0] vector_input_lines,
    output logic wait_n
);
    int cnt_q;
    logic [7:0] junk_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            junk_q <= 8'h5a;
        end else begin
            cnt_q <= vector_fetch_strobe_n ? 0 : cnt_q + 1;
            junk_q <= ~junk_q;
        end
    end
    // stretch the fetch by the asked number of cycles
    assign wait_n = vector_fetch_strobe_n || cnt_q >= waits;
    // top line held low keeps the vector in seven bits
    assign vector_input_lines = vector_fetch_strobe_n ? junk_q : {1'b0, vec};
endmodule

// File: tb/isp_top_tb.sv
// Purpose: self-checking bench of the interrupt source prioritizer
// Assumes: zero wait bus slave, word accesses
// Notes: expectations worked out from levels and bases set here
`timescale 1ns/1ps
module isp_top_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hresp, hreadyout;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, exc_table_addr, vbase;
    logic [1:0] htrans = 0;
    logic debug_port_req = 0, exc_ready = 0, exc_valid, wait_n, vector_fetch_strobe_n;
    logic [3:0] level_request_pins = 4'hf, cpu_mask_level = 0, exc_mask_level, level_output_lines, lvl;
    logic [39:0] peri_irq = 0;
    logic [6:0] exc_vector, ext_vec = 7'h40;
    logic [7:0] vector_input_lines;
    logic [4:0] chip_selects_n, bus_cs_n = 5'h1f;
    logic [20:0] upper_address_lines, bus_upper_addr = 0;
    logic [3:0] bus_low_addr = 0;
    int seed = 97, errors = 0, compares = 0, ext_waits = 0, i;
    always #50 hclk = ~hclk;
    always @(posedge hclk) {bus_low_addr, bus_cs_n, bus_upper_addr} <= 30'($random(seed));
    isp_top #(.N_PERI(40)) u_isp_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .debug_port_req, .level_request_pins, .peri_irq,
        .cpu_mask_level, .exc_valid, .exc_ready, .exc_vector, .exc_table_addr, .exc_mask_level,
        .vector_input_lines, .wait_n, .vector_fetch_strobe_n, .level_output_lines, .chip_selects_n,
        .upper_address_lines, .bus_low_addr, .bus_cs_n, .bus_upper_addr);
    isp_vec_agent u_isp_vec_agent (.hclk, .hresetn, .vector_fetch_strobe_n, .vec(ext_vec), .waits(ext_waits),
        .vector_input_lines, .wait_n);
    ////////////////////////////////////////
    function automatic logic [6:0] auto_vec(input int l);
        return 7'(64 + l / 2);
    endfunction
    task automatic test_done;
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            test_done;
        end
    endtask
    // one word transfer; a read compares against d
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        if (!w) chk(hrdata, d);
    endtask
    task automatic quiet;
        repeat (4) begin
            @(posedge hclk);
            chk(exc_valid, 1'b0);
        end
    endtask
    task automatic take(input logic [3:0] l, input logic [6:0] vec);
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
            if (vector_fetch_strobe_n === 1'b0) chk(level_output_lines, l);
            else chk(upper_address_lines, bus_upper_addr);
        end while (exc_valid !== 1'b1 && k < 50);
        chk(exc_valid, 1'b1);
        if (exc_valid !== 1'b1) test_done;
        chk(exc_vector, vec);
        chk(exc_mask_level, l);
        chk(exc_table_addr, vbase + {23'h0, vec, 2'h0});
        exc_ready <= 1'b1;
        cpu_mask_level <= 4'hf;
        @(posedge hclk);
        exc_ready <= 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 5; i++) bus(8'(isp_pkg::OFS_PRI0 + 4 * i), 1'b0, 32'h0);
        vbase = $random(seed) & 32'hffff_ff00;
        bus(isp_pkg::OFS_VBASE, 1'b1, vbase);
        bus(isp_pkg::OFS_VBASE, 1'b0, vbase);
        bus(8'h3c, 1'b1, 32'hffff_ffff);
        bus(8'h3c, 1'b0, 32'h0);
        bus(isp_pkg::OFS_PVEC, 1'b1, 32'h10);
        debug_port_req <= 1'b1;
        @(posedge hclk);
        debug_port_req <= 1'b0;
        take(4'hf, 7'h0d);
        for (i = 0; i < 15; i++) begin
            lvl = 4'(15 - i);
            level_request_pins <= 4'(i);
            cpu_mask_level <= lvl;
            quiet;
            cpu_mask_level <= lvl - 4'h1;
            take(lvl, auto_vec(lvl));
        end
        level_request_pins <= 4'hf;
        cpu_mask_level <= 4'h0;
        quiet;
        bus(isp_pkg::OFS_CTRL, 1'b1, 32'h1);
        for (i = 0; i < 2; i++) begin
            ext_vec = 7'h40 | 7'($random(seed));
            ext_waits = 2 * i;
            level_request_pins <= 4'h3;
            cpu_mask_level <= 4'h0;
            take(4'hc, ext_vec);
            level_request_pins <= 4'hf;
            @(posedge hclk);
        end
        bus(isp_pkg::OFS_SENSE, 1'b1, 32'he400);
        bus(isp_pkg::OFS_PINPRI, 1'b1, 32'h6543);
        bus(isp_pkg::OFS_CTRL, 1'b1, 32'h2);
        for (i = 0; i < 4; i++) begin
            if (i == 3) bus(isp_pkg::OFS_CTRL, 1'b1, 32'h3);
            level_request_pins[i] <= 1'b0;
            cpu_mask_level <= 4'h0;
            if (i == 2) begin
                quiet;
                level_request_pins[2] <= 1'b1;
            end
            take(4'(i + 3), i == 3 ? ext_vec : auto_vec(i + 3));
            level_request_pins <= 4'hf;
            bus(isp_pkg::OFS_SENSE, 1'b1, 32'he40f);
            @(posedge hclk);
        end
        bus(isp_pkg::OFS_SENSE, 1'b0, 32'h0000_e4f0);
        bus(isp_pkg::OFS_CTRL, 1'b1, 32'h0);
        bus(isp_pkg::OFS_PRI0, 1'b1, 32'h5000);
        bus(isp_pkg::OFS_PRI0, 1'b0, 32'h5000);
        peri_irq <= 40'h7;
        level_request_pins <= 4'ha;
        cpu_mask_level <= 4'h0;
        take(4'h5, auto_vec(5));
        level_request_pins <= 4'hf;
        @(posedge hclk);
        cpu_mask_level <= 4'h0;
        take(4'h5, 7'h10);
        peri_irq[0] <= 1'b0;
        @(posedge hclk);
        cpu_mask_level <= 4'h0;
        take(4'h5, 7'h11);
        peri_irq[1] <= 1'b0;
        @(posedge hclk);
        cpu_mask_level <= 4'h0;
        quiet;
        bus(isp_pkg::OFS_PRI0, 1'b1, 32'h5300);
        take(4'h3, 7'h12);
        bus(isp_pkg::OFS_STAT, 1'b0, 32'h0000_0312);
        // mid-run reset must clear the priorities written above
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(isp_pkg::OFS_PRI0, 1'b0, 32'h0);
        test_done;
    end
endmodule
bind isp_top isp_assertions u_isp_assertions (.hclk, .hresetn, .hreadyout, .hresp, .cpu_mask_level, .exc_valid,
    .exc_ready, .exc_vector, .exc_mask_level, .vector_input_lines, .wait_n, .vector_fetch_strobe_n,
    .level_output_lines, .chip_selects_n, .bus_low_addr, .bus_cs_n);
